// *** common/qhps_pkg.sv ***
// package: register map, constants and types of the qbus host port sequencer
package qhps_pkg;
  // ---------------------------------------------------------------
  // apb register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_IP   = 8'h08;
  localparam logic [7:0] A_SA   = 8'h0c;
  localparam logic [7:0] A_DADR = 8'h10;
  localparam logic [7:0] A_DCNT = 8'h14;
  localparam logic [7:0] A_DWD  = 8'h18;
  localparam logic [7:0] A_DRD  = 8'h1c;
  localparam logic [7:0] A_VEC  = 8'h20;
  localparam logic [7:0] A_BOOT = 8'h40;
  localparam logic [7:0] A_BOOT_MASK = 8'he0;
  // ---------------------------------------------------------------
  // host address options: six base pairs, two bootstrap windows
  // ---------------------------------------------------------------
  localparam logic [7:0][21:0] ADDR_OPT = {22'h3ff200, 22'h3ff600, 22'h3ff450, 22'h3ff440,
                                            22'h3ff430, 22'h3ff420, 22'h3ff410, 22'h3ff400};
  localparam logic [7:0][21:0] ADDR_MASK = {22'h3ffff0, 22'h3ffff0, {6{22'h3ffffc}}};
  localparam logic [2:0] BOOT_OPT0 = 3'h6;
  localparam logic [2:0] BOOT_LAST = 3'h7;
  // ---------------------------------------------------------------
  // timing, datapath and condition select constants
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TMO_NS  = 10000;
  localparam logic [9:0] TMO_CYC = 10'((TMO_NS * CLK_MHZ + 999) / 1000);
  localparam logic [1:0] RG_PCL = 2'h0;
  localparam logic [1:0] RG_PCH = 2'h1;
  localparam logic [1:0] RG_OPC = 2'h2;
  localparam logic [1:0] RG_CNT = 2'h3;
  localparam logic [21:0] DADR_STEP = 22'h000002;
  localparam logic [4:0] CB_SYNC  = 5'h00;
  localparam logic [4:0] CB_STRB  = 5'h01;
  localparam logic [4:0] CB_GRANT = 5'h02;
  localparam logic [4:0] CB_RPLY  = 5'h03;
  localparam logic [9:0] U_SLV   = 10'h040;
  localparam logic [9:0] U_VEC   = 10'h080;
  localparam logic [9:0] U_DMA   = 10'h200;
  localparam logic [9:0] U_FETCH = 10'h000;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [11:0] {
    ST_IDLE = 12'h001, ST_FETCH = 12'h002, ST_FETCH2 = 12'h004, ST_SLV = 12'h008,
    ST_DRV  = 12'h010, ST_DREQ  = 12'h020, ST_DADR   = 12'h040, ST_DDRV = 12'h080,
    ST_DSYN = 12'h100, ST_DDAT  = 12'h200, ST_DNXT   = 12'h400, ST_DEND = 12'h800
  } qhps_state_t;
  typedef struct packed {
    logic [20:0] rsvd;
    logic        dma_dir;
    logic        dma_go;
    logic        irq_set;
    logic [2:0]  prio;
    logic        boot_sel;
    logic        boot_en;
    logic [2:0]  base_sel;
  } qhps_ctrl_t;
  typedef struct packed {
    logic [14:0] rsvd;
    logic        bootv;
    logic        pollv;
    logic        initv;
    logic        tmo;
    logic        perr;
    logic        blk;
    logic        busy;
    logic [9:0]  uaddr;
  } qhps_stat_t;
  typedef struct packed {
    logic [21:0] dal;
    logic sync, din, dout, wtbt, iack_in, dmg_in, bref, rply, perr;
  } qhps_qin_t;
  typedef struct packed {
    logic [21:0] dal;
    logic oe_lo_n, oe_hi_n, ld_lo, ld_hi, ld_top;
    logic [3:0] irq;
    logic internal_dma_request, sack, sync, din, dout, wtbt, rply, boot_start;
  } qhps_qout_t;
  typedef struct packed {
    qhps_qin_t s1, s2;
    logic syncp, hit, a1, read_direction, bt;
    logic [2:0] bidx;
    logic hit_s, a1_s, read_direction_s, bt_s;
    logic [2:0] bidx_s;
    qhps_state_t st;
    logic [9:0] uaddr;
    qhps_ctrl_t ctrl;
    logic irqp, dgo, blk, perr, tmo, initv, pollv, bootv;
    logic [15:0] ipf, iph, saf, sah, dwd, drd, vec;
    logic [21:0] dadr;
    logic [7:0][15:0] boot;
    logic [3:0][7:0] register_arith_unit;
    logic [9:0] tcnt;
    logic [15:0] fwa;
    logic fwr;
    qhps_qout_t qo;
    logic [31:0] prdata;
    logic pready, pslverr;
  } qhps_st_t;
endpackage : qhps_pkg

// *** hdl/qhps_top.sv ***
// qbus host port and microprogrammed sequencer of a disc controller board
//
// Overview of operation
// - Provide init/poll and status/address registers; service every host access to them.
// - With auto-boot enabled, answer eight boot words at chosen base, then start bootstrap.
// - Act as slave for data-in, data-out and read-modify-write cycles only.
// - Support interrupt and dma cycles, driving full 22-bit addresses in both dma modes.
// - Decode host addresses into six base and two boot matches; links pick one base and, with auto-boot enabled, one boot window.
// - Latch chosen match with address bit 1 and direction, synchronise, start service.
// - Multiplex incoming 16-bit bus data onto the internal data bus.
// - Load outgoing latches with separate low, high and top-address strobes.
// - Enable low and high bus drivers only after latches hold outgoing data.
// - Interrupt request always raises level 4; priority links add levels 5, 6, 7.
// - Host answers with data-in and acknowledge; device then runs vector transfer.
// - Raise dma request; on grant from host, start the transfer routine.
// - After grant, assert master select acknowledge before transferring any data.
// - Use block mode when memory signals it on refresh line, else burst mode.
// - Detect memory parity and bus timeout errors during dma.
// - Dispatch store drives routine start address; next edge hands over to next-address store.
// - Next-address store steps each edge; routine end returns control to dispatch.
// - Microaddress bit 0 takes one of 22 conditions chosen per step by branch select.
// - Top microaddress bit comes from a control store output; stores decode control.
// - With nothing pending, fetch: pc to address latch, read firmware, byte to microaddress.
// - An 8-bit register and arithmetic unit holds pc, opcode and transfer count.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
module qhps_top (
  // apb slave
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // qbus backplane
  input  wire qhps_pkg::qhps_qin_t qbus_rx,
  output qhps_pkg::qhps_qout_t     qbus_tx,
  // firmware prom
  output logic [15:0]             fw_addr,
  output logic                    fw_rd,
  input  wire logic [7:0]         fw_data
);
  qhps_pkg::qhps_st_t   q;
  qhps_pkg::qhps_st_t   n;
  qhps_pkg::qhps_ctrl_t wc;
  qhps_pkg::qhps_stat_t stat;
  qhps_pkg::qhps_stat_t wstat;
  logic [31:0]          rd;
  logic                 rderr;
  logic [7:0]           amatch;
  logic [23:0]          cond;
  logic [4:0]           bsel;
  logic [8:0]           alu;
  logic                 ctl_top;
  logic [15:0]          inbus;

  // 8-bit adder of the register and arithmetic unit
  function automatic logic [8:0] qhps_alu(input logic [7:0] a, input logic [7:0] b, input logic ci);
    qhps_alu = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction : qhps_alu

  // ---------------------------------------------------------------
  // address decode store: one comparator per address option
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_dec
    assign amatch[i] = ((q.s2.dal ^ qhps_pkg::ADDR_OPT[i]) & qhps_pkg::ADDR_MASK[i]) == 22'h000000;
  end

  // 22 live conditions, grouped as three 8-input selectors; top two unused
  assign cond = {2'b00, q.tmo, q.perr, q.blk, q.dgo, q.irqp, q.bt_s, q.read_direction_s, q.a1_s, q.hit_s,
                 q.initv, q.pollv, q.bootv, (q.register_arith_unit[qhps_pkg::RG_CNT] == 8'h00), q.s2.perr,
                 q.s2.bref, q.s2.iack_in, q.s2.wtbt, q.s2.dout, q.s2.rply, q.s2.dmg_in,
                 (q.s2.din | q.s2.dout), q.s2.sync};
  assign inbus = q.s2.dal[15:0];
  assign ctl_top = q.st inside {qhps_pkg::ST_DREQ, qhps_pkg::ST_DADR, qhps_pkg::ST_DDRV,
                                qhps_pkg::ST_DSYN, qhps_pkg::ST_DDAT, qhps_pkg::ST_DNXT,
                                qhps_pkg::ST_DEND};
  assign wc = qhps_pkg::qhps_ctrl_t'(pwdata);
  // clear mask read through the status layout, so event bit positions live in one place
  assign wstat = qhps_pkg::qhps_stat_t'(pwdata);

  // status word as software sees it
  always_comb begin
    stat = '0;
    stat.bootv = q.bootv;
    stat.pollv = q.pollv;
    stat.initv = q.initv;
    stat.tmo = q.tmo;
    stat.perr = q.perr;
    stat.blk = q.blk;
    stat.busy = q.dgo;
    stat.uaddr = q.uaddr;
  end

  // ---------------------------------------------------------------
  // next state: apb, address latch, sequencer
  // ---------------------------------------------------------------
  always_comb begin
    n = q;
    rd = 32'h00000000;
    rderr = 1'b0;
    bsel = qhps_pkg::CB_SYNC;
    alu = 9'h000;
    n.qo.ld_lo = 1'b0;
    n.qo.ld_hi = 1'b0;
    n.qo.ld_top = 1'b0;
    n.qo.boot_start = 1'b0;
    n.fwr = 1'b0;
    n.s1 = qbus_rx;
    n.s2 = q.s1;
    n.syncp = q.s2.sync;
    // register read mux, answered after one wait state
    case (paddr)
      qhps_pkg::A_CTRL: rd = q.ctrl;
      qhps_pkg::A_STAT: rd = stat;
      qhps_pkg::A_IP:   rd = {16'h0000, q.iph};
      qhps_pkg::A_SA:   rd = {16'h0000, q.sah};
      qhps_pkg::A_DADR: rd = {10'h000, q.dadr};
      qhps_pkg::A_DCNT: rd = {24'h000000, q.register_arith_unit[qhps_pkg::RG_CNT]};
      qhps_pkg::A_DWD:  rd = {16'h0000, q.dwd};
      qhps_pkg::A_DRD:  rd = {16'h0000, q.drd};
      qhps_pkg::A_VEC:  rd = {16'h0000, q.vec};
      default: begin
        if ((paddr & qhps_pkg::A_BOOT_MASK) == qhps_pkg::A_BOOT) rd = {16'h0000, q.boot[paddr[4:2]]};
        else rderr = 1'b1;
      end
    endcase
    n.pready = psel && penable && !q.pready;
    if (psel && penable && !q.pready) begin
      n.prdata = pwrite ? 32'h00000000 : rd;
      n.pslverr = rderr;
    end
    // writes land on the edge that samples pready high
    if (psel && penable && q.pready && pwrite) begin
      case (paddr)
        qhps_pkg::A_CTRL: begin
          n.ctrl = wc;
          n.ctrl.irq_set = 1'b0;
          n.ctrl.dma_go = 1'b0;
          if (wc.irq_set) n.irqp = 1'b1;
          if (wc.dma_go) n.dgo = 1'b1;
        end
        qhps_pkg::A_STAT: begin
          n.bootv = q.bootv & ~wstat.bootv;
          n.pollv = q.pollv & ~wstat.pollv;
          n.initv = q.initv & ~wstat.initv;
        end
        qhps_pkg::A_IP:   n.ipf = pwdata[15:0];
        qhps_pkg::A_SA:   n.saf = pwdata[15:0];
        qhps_pkg::A_DADR: n.dadr = pwdata[21:0];
        qhps_pkg::A_DCNT: n.register_arith_unit[qhps_pkg::RG_CNT] = pwdata[7:0];
        qhps_pkg::A_DWD:  n.dwd = pwdata[15:0];
        qhps_pkg::A_VEC:  n.vec = pwdata[15:0];
        default: if ((paddr & qhps_pkg::A_BOOT_MASK) == qhps_pkg::A_BOOT) n.boot[paddr[4:2]] = pwdata[15:0];
      endcase
    end
    // address latch on a host sync edge, then the synchronising stage
    if (q.s2.sync && !q.syncp && !q.qo.sack) begin
      n.hit = amatch[q.ctrl.base_sel] | (q.ctrl.boot_en & amatch[qhps_pkg::BOOT_OPT0 + {2'b00, q.ctrl.boot_sel}]);
      n.bt = !amatch[q.ctrl.base_sel];
      n.a1 = q.s2.dal[1];
      n.bidx = q.s2.dal[3:1];
      n.read_direction = !q.s2.wtbt;
    end
    n.hit_s = q.hit;
    n.a1_s = q.a1;
    n.read_direction_s = q.read_direction;
    n.bt_s = q.bt;
    n.bidx_s = q.bidx;
    // microaddress: successor from next-address store, bit 0 from the branch select
    if (q.st != qhps_pkg::ST_IDLE) n.uaddr = {ctl_top, q.uaddr[8:1] + 8'h01, 1'b0};
    unique case (q.st)
      qhps_pkg::ST_IDLE: begin
        // dispatch store: pick a routine and drive its start address
        if (q.hit_s) begin
          n.uaddr = qhps_pkg::U_SLV;
          n.st = qhps_pkg::ST_SLV;
        end else if (q.irqp && q.s2.iack_in && q.s2.din) begin
          n.uaddr = qhps_pkg::U_VEC;
          n.qo.dal[7:0] = q.vec[7:0];
          n.qo.dal[15:8] = q.vec[15:8];
          n.qo.ld_lo = 1'b1;
          n.qo.ld_hi = 1'b1;
          n.irqp = 1'b0;
          n.st = qhps_pkg::ST_DRV;
        end else if (q.dgo) begin
          n.uaddr = qhps_pkg::U_DMA;
          n.perr = 1'b0;
          n.tmo = 1'b0;
          n.st = qhps_pkg::ST_DREQ;
        end else begin
          n.uaddr = qhps_pkg::U_FETCH;
          n.st = qhps_pkg::ST_FETCH;
        end
      end
      qhps_pkg::ST_FETCH: begin
        // program counter to the firmware address latch, read strobe on the same edge
        n.fwa = {q.register_arith_unit[qhps_pkg::RG_PCH], q.register_arith_unit[qhps_pkg::RG_PCL]};
        n.fwr = 1'b1;
        alu = qhps_alu(q.register_arith_unit[qhps_pkg::RG_PCL], 8'h01, 1'b0);
        n.register_arith_unit[qhps_pkg::RG_PCL] = alu[7:0];
        n.register_arith_unit[qhps_pkg::RG_PCH] = 8'(qhps_alu(q.register_arith_unit[qhps_pkg::RG_PCH], 8'h00, alu[8]));
        n.st = qhps_pkg::ST_FETCH2;
      end
      qhps_pkg::ST_FETCH2: begin
        n.register_arith_unit[qhps_pkg::RG_OPC] = fw_data;
        n.uaddr = {2'b00, fw_data};
        n.st = qhps_pkg::ST_IDLE;
      end
      qhps_pkg::ST_SLV: begin
        bsel = qhps_pkg::CB_STRB;
        if (q.s2.din && q.read_direction_s) begin
          n.qo.dal[15:0] = q.bt_s ? q.boot[q.bidx_s] : (q.a1_s ? q.saf : q.ipf);
          n.qo.ld_lo = 1'b1;
          n.qo.ld_hi = 1'b1;
          if (!q.bt_s && !q.a1_s) n.pollv = 1'b1;
          if (q.bt_s && q.bidx_s == qhps_pkg::BOOT_LAST) begin
            n.qo.boot_start = 1'b1;
            n.bootv = 1'b1;
          end
          n.st = qhps_pkg::ST_DRV;
        end else if (q.s2.dout) begin
          if (!q.bt_s && q.a1_s) n.sah = inbus;
          if (!q.bt_s && !q.a1_s) begin
            n.iph = inbus;
            n.initv = 1'b1;
          end
          n.qo.rply = 1'b1;
          n.st = qhps_pkg::ST_DRV;
        end else if (!q.s2.sync) begin
          n.hit = 1'b0;
          n.hit_s = 1'b0;
          n.st = qhps_pkg::ST_IDLE;
        end
      end
      qhps_pkg::ST_DRV: begin
        // drivers go on only the cycle after the latches were loaded
        bsel = qhps_pkg::CB_STRB;
        if (q.qo.ld_lo) begin
          n.qo.oe_lo_n = 1'b0;
          n.qo.oe_hi_n = 1'b0;
        end
        n.qo.rply = 1'b1;
        if (!q.s2.din && !q.s2.dout) begin
          n.qo.oe_lo_n = 1'b1;
          n.qo.oe_hi_n = 1'b1;
          n.qo.rply = 1'b0;
          n.st = q.hit_s ? qhps_pkg::ST_SLV : qhps_pkg::ST_IDLE;
        end
      end
      qhps_pkg::ST_DREQ: begin
        bsel = qhps_pkg::CB_GRANT;
        n.qo.internal_dma_request = 1'b1;
        if (q.s2.dmg_in) begin
          n.qo.internal_dma_request = 1'b0;
          n.qo.sack = 1'b1;
          n.st = qhps_pkg::ST_DADR;
        end
      end
      qhps_pkg::ST_DADR: begin
        n.qo.dal = q.dadr;
        n.qo.ld_lo = 1'b1;
        n.qo.ld_hi = 1'b1;
        n.qo.ld_top = 1'b1;
        n.qo.wtbt = q.ctrl.dma_dir;
        n.st = qhps_pkg::ST_DDRV;
      end
      qhps_pkg::ST_DDRV: begin
        n.qo.oe_lo_n = 1'b0;
        n.qo.oe_hi_n = 1'b0;
        n.st = qhps_pkg::ST_DSYN;
      end
      qhps_pkg::ST_DSYN: begin
        n.qo.sync = 1'b1;
        n.blk = 1'b0; // refresh line is only meaningful once memory has seen sync
        if (q.ctrl.dma_dir) begin
          n.qo.dal[15:0] = q.dwd;
          n.qo.ld_lo = 1'b1;
          n.qo.ld_hi = 1'b1;
        end else begin
          n.qo.oe_lo_n = 1'b1;
          n.qo.oe_hi_n = 1'b1;
        end
        n.tcnt = 10'h000;
        n.st = qhps_pkg::ST_DDAT;
      end
      qhps_pkg::ST_DDAT: begin
        bsel = qhps_pkg::CB_RPLY;
        n.qo.din = !q.ctrl.dma_dir;
        n.qo.dout = q.ctrl.dma_dir;
        n.tcnt = q.tcnt + 10'h001;
        if (q.s2.rply) begin
          if (!q.ctrl.dma_dir) n.drd = inbus;
          if (!q.ctrl.dma_dir && q.s2.perr) n.perr = 1'b1;
          n.blk = q.s2.bref;
          n.register_arith_unit[qhps_pkg::RG_CNT] = 8'(qhps_alu(q.register_arith_unit[qhps_pkg::RG_CNT], 8'hff, 1'b0));
          n.qo.din = 1'b0;
          n.qo.dout = 1'b0;
          n.st = qhps_pkg::ST_DNXT;
        end else if (q.tcnt == qhps_pkg::TMO_CYC - 10'h001) begin
          n.tmo = 1'b1;
          n.st = qhps_pkg::ST_DEND;
        end
      end
      qhps_pkg::ST_DNXT: begin
        bsel = qhps_pkg::CB_RPLY;
        if (!q.s2.rply) begin
          n.dadr = q.dadr + qhps_pkg::DADR_STEP;
          n.tcnt = 10'h000;
          if (q.perr || q.register_arith_unit[qhps_pkg::RG_CNT] == 8'h00) begin
            n.st = qhps_pkg::ST_DEND;
          end else if (q.blk) begin
            if (q.ctrl.dma_dir) begin
              n.qo.dal[15:0] = q.dwd;
              n.qo.ld_lo = 1'b1;
              n.qo.ld_hi = 1'b1;
            end
            n.st = qhps_pkg::ST_DDAT;
          end else begin
            n.qo.sync = 1'b0;
            n.qo.oe_lo_n = 1'b1;
            n.qo.oe_hi_n = 1'b1;
            n.st = qhps_pkg::ST_DADR;
          end
        end
      end
      qhps_pkg::ST_DEND: begin
        // hand the bus back to the host
        n.qo.internal_dma_request = 1'b0;
        n.qo.sack = 1'b0;
        n.qo.sync = 1'b0;
        n.qo.din = 1'b0;
        n.qo.dout = 1'b0;
        n.qo.wtbt = 1'b0;
        n.qo.oe_lo_n = 1'b1;
        n.qo.oe_hi_n = 1'b1;
        n.dgo = 1'b0;
        n.st = qhps_pkg::ST_IDLE;
      end
    endcase
    if (q.st != qhps_pkg::ST_IDLE && q.st != qhps_pkg::ST_FETCH2) n.uaddr[0] = cond[bsel];
    // level 4 always, upper levels as the priority links allow
    n.qo.irq = {n.ctrl.prio & {3{n.irqp}}, n.irqp};
  end

  // state register; reset leaves drivers off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= qhps_pkg::ST_IDLE;
      q.qo.oe_lo_n <= 1'b1;
      q.qo.oe_hi_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign qbus_tx = q.qo;
  assign fw_addr = q.fwa;
  assign fw_rd = q.fwr;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_irq_level4: assert property (q.irqp |-> qbus_tx.irq[0])
    else $error("level 4 request missing");
  chk_irq_prio: assert property (qbus_tx.irq[3:1] == (q.ctrl.prio & {3{qbus_tx.irq[0]}}))
    else $error("priority levels wrong");
  chk_drv_after_load: assert property ($fell(qbus_tx.oe_lo_n) |-> $past(qbus_tx.ld_lo))
    else $error("driver enabled before latch load");
  chk_sack_on_grant: assert property ($rose(qbus_tx.sack) |-> $past(q.s2.dmg_in) && !qbus_tx.internal_dma_request)
    else $error("master ack without grant");
  chk_strobe_master: assert property (qbus_tx.sync |-> qbus_tx.sack)
    else $error("master strobe without ack");
  chk_dma_release: assert property (q.st == qhps_pkg::ST_DEND |=> !qbus_tx.internal_dma_request && !qbus_tx.sack)
    else $error("bus not released");
  chk_dispatch_slv: assert property (q.st == qhps_pkg::ST_IDLE && q.hit_s |=>
      q.st == qhps_pkg::ST_SLV && q.uaddr == qhps_pkg::U_SLV)
    else $error("dispatch start address wrong");
  chk_next_addr: assert property (q.st == qhps_pkg::ST_SLV && !$past(q.st == qhps_pkg::ST_IDLE) |->
      q.uaddr[8:1] == $past(q.uaddr[8:1]) + 8'h01)
    else $error("next address not successor");
  chk_dma_timeout: assert property (q.st == qhps_pkg::ST_DDAT && !q.s2.rply &&
      q.tcnt == qhps_pkg::TMO_CYC - 10'h001 |=> q.tmo && q.st == qhps_pkg::ST_DEND)
    else $error("timeout not flagged");
  chk_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing");
  chk_grant_start: assert property (q.st == qhps_pkg::ST_DREQ && q.s2.dmg_in |=>
      q.st == qhps_pkg::ST_DADR ##1 qbus_tx.ld_top)
    else $error("grant not serviced");
endmodule : qhps_top

// *** dv/qhps_qhost.sv ***
// host processor and main memory model on the far side of the backplane
`timescale 1ns/1ns
module qhps_qhost (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // bench side: memory mode, host cycle lines, last memory write
  input  wire logic [1:0]           mode,
  input  wire qhps_pkg::qhps_qin_t  hq,
  output logic [37:0]               wr_q,
  // backplane
  input  wire qhps_pkg::qhps_qout_t tx,
  output qhps_pkg::qhps_qin_t       rx
);
  logic        ia_q;
  logic        ik_q;
  logic        gnt_q;
  logic        rp_q;
  logic [21:0] ma_q;
  // mode 0 burst, 1 block capable, 2 memory never replies, 3 parity fault on reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ia_q, ik_q, gnt_q, rp_q, ma_q, wr_q} <= '0;
    end else begin
      gnt_q <= tx.internal_dma_request & !tx.sack;
      ia_q  <= tx.irq[0] | (ia_q & !tx.rply);
      ik_q  <= ia_q & !tx.rply;
      rp_q  <= mode != 2'h2 && tx.sync && (tx.din || tx.dout);
      // block mode keeps its own address count, as real memory does
      if (!tx.sync) ma_q <= tx.dal;
      else if (rp_q && !tx.din && !tx.dout) ma_q <= ma_q + 22'h2;
      if (tx.dout && !rp_q) wr_q <= {ma_q, tx.dal[15:0]};
    end
  end
  // lines nobody drives show the inverse of the latch, never a stale copy
  assign rx = '{dal: hq.sync ? hq.dal : (tx.din && rp_q) ? {6'h0, ma_q[15:0] ^ 16'ha5a5} : ~tx.dal,
                sync: hq.sync, din: hq.din | ia_q, dout: hq.dout, wtbt: hq.wtbt, iack_in: ik_q,
                dmg_in: gnt_q, bref: mode == 2'h1 && tx.sync, rply: rp_q,
                perr: mode == 2'h3 && rp_q && tx.din};
endmodule : qhps_qhost

// *** dv/qbus_host_port_sequencer_test.sv ***
// self-checking bench of the qbus host port sequencer
`timescale 1ns/1ns
module qbus_host_port_sequencer_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, fw_rd, err;
  logic [7:0]  paddr = '0, fw_data = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] fw_addr, d, v;
  logic [1:0]  mode = '0;
  logic [37:0] wr;
  logic [21:0] a;
  logic [2:0]  p;
  logic [1:0]  md [5] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3};
  logic [2:0]  ex [5] = '{3'h0, 3'h1, 3'h0, 3'h4, 3'h2};
  qhps_pkg::qhps_qin_t  hq = '0, rx;
  qhps_pkg::qhps_qout_t tx;
  int error_cnt = 0, total_checks = 0, cyc = 0, bs = 0, nf = 0;
  qhps_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .qbus_rx(rx), .qbus_tx(tx), .fw_addr(fw_addr), .fw_rd(fw_rd), .fw_data(fw_data));
  qhps_qhost u_host (.pclk(pclk), .presetn(presetn), .mode(mode), .hq(hq), .wr_q(wr), .tx(tx), .rx(rx));
  always #5 pclk = ~pclk;
  // firmware bytes, event counts and the hang limit
  always @(posedge pclk) begin
    fw_data <= 8'($urandom);
    bs += int'(tx.boot_start === 1'b1);
    nf += int'(fw_rd === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [37:0] g, input logic [37:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // host data cycle; a read leaves the word in v
  task automatic qcyc(input logic w, input logic [21:0] ad, input logic [15:0] wd);
    hq.dal  <= ad;
    hq.wtbt <= w;
    @(posedge pclk);
    hq.sync <= 1'b1;
    repeat (4) @(posedge pclk);
    hq.dal  <= w ? {6'h0, wd} : ~ad;
    hq.din  <= !w;
    hq.dout <= w;
    while (tx.rply !== 1'b1) @(posedge pclk);
    v = tx.dal[15:0];
    hq.din  <= 1'b0;
    hq.dout <= 1'b0;
    while (tx.rply !== 1'b0) @(posedge pclk);
    hq.sync <= 1'b0;
    @(posedge pclk);
  endtask : qcyc
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    void'($urandom(32'hab9f7dc2));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h24, '0);
    chk({rd[30:0], err}, 32'h1);
    for (int b = 0; b < 6; b++) begin
      d = 16'($urandom);
      apb(1'b1, qhps_pkg::A_CTRL, 32'(b));
      qcyc(1'b1, qhps_pkg::ADDR_OPT[b], d);
      apb(1'b0, qhps_pkg::A_IP, '0);
      chk(rd[15:0], d);
      apb(1'b1, qhps_pkg::A_SA, 32'(~d));
      qcyc(1'b0, qhps_pkg::ADDR_OPT[b] + 22'h2, '0);
      chk(v, 16'(~d));
    end
    apb(1'b1, qhps_pkg::A_CTRL, 32'h8);
    for (int i = 0; i < 8; i++) apb(1'b1, qhps_pkg::A_BOOT + 8'(4 * i), 32'h0b00 + 32'(i));
    for (int i = 0; i < 8; i++) begin
      qcyc(1'b0, qhps_pkg::ADDR_OPT[qhps_pkg::BOOT_OPT0] + 22'(2 * i), '0);
      chk(v, 16'h0b00 + 16'(i));
    end
    // second bootstrap window, word 1
    apb(1'b1, qhps_pkg::A_CTRL, 32'h18);
    qcyc(1'b0, qhps_pkg::ADDR_OPT[qhps_pkg::BOOT_LAST] + 22'h2, '0);
    chk(v, 16'h0b01);
    chk(bs, 1);
    apb(1'b0, qhps_pkg::A_STAT, '0);
    chk(rd[16:14], 3'h5);
    apb(1'b1, qhps_pkg::A_STAT, 32'h1c000);
    apb(1'b0, qhps_pkg::A_STAT, '0);
    chk(rd[16:14], 3'h0);
    for (int i = 0; i < 8; i++) begin
      p = 3'(i);
      d = 16'($urandom);
      apb(1'b1, qhps_pkg::A_VEC, 32'(d));
      apb(1'b1, qhps_pkg::A_CTRL, {23'h0, 1'b1, p, 5'h0});
      while (tx.irq[0] !== 1'b1) @(posedge pclk);
      chk(tx.irq, {p, 1'b1});
      while (tx.rply !== 1'b1) @(posedge pclk);
      chk(tx.dal[15:0], d);
      while (tx.rply !== 1'b0) @(posedge pclk);
    end
    // dma: burst write, block write, burst read, silent memory, parity fault
    for (int i = 0; i < 5; i++) begin
      mode <= md[i];
      a = 22'($urandom) & 22'h3ffffe;
      d = 16'($urandom);
      apb(1'b1, qhps_pkg::A_DADR, 32'(a));
      apb(1'b1, qhps_pkg::A_DCNT, i < 3 ? 32'h3 : 32'h1);
      apb(1'b1, qhps_pkg::A_DWD, 32'(d));
      apb(1'b1, qhps_pkg::A_CTRL, i < 2 ? 32'h600 : 32'h200);
      do apb(1'b0, qhps_pkg::A_STAT, '0); while (rd[10] !== 1'b0);
      chk(rd[13:11], ex[i]);
      chk({tx.internal_dma_request, tx.sack}, 2'h0);
      if (i < 2) chk(wr, {a + 22'h4, d});
      apb(1'b0, qhps_pkg::A_DRD, '0);
      if (i == 2) chk(rd[15:0], (a[15:0] + 16'h4) ^ 16'ha5a5);
    end
    chk(32'(nf != 0), 1);
    end_sim();
  end
endmodule : qbus_host_port_sequencer_test
